// ==== include/mmsl_pkg.sv ====
// mmsl_pkg: shared types, register map and timing for the sync link
// assumes a 125 MHz core clock and a 48 MHz local reference
package mmsl_pkg;
  // ==========================================================
  // modes, states and carriers
  typedef enum logic [1:0] {
    MMSL_NONE = 2'b00, MMSL_MASTER = 2'b01, MMSL_SLAVE = 2'b10
  } mmsl_mode_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ARMED = 3'b001, S_RUN = 3'b010,
    S_POST = 3'b011, S_STOPW = 3'b100
  } mmsl_state_t;
  typedef struct packed {
    mmsl_mode_t mode;
    logic arm;
    logic stop;
    logic ref_en;
    logic [15:0] div;
    logic [15:0] post;
  } mmsl_ctl_t;
  typedef struct packed {
    mmsl_state_t state;
    logic sample;
    logic started;
    logic done;
  } mmsl_sts_t;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_CMD = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h0c;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFF_AI_DIV = 8'h14;
  localparam logic [7:0] OFF_AO_DIV = 8'h18;
  localparam logic [7:0] OFF_AI_POST = 8'h1c;
  localparam logic [7:0] OFF_AO_POST = 8'h20;
  // ==========================================================
  // field positions and reset values
  localparam int CF_AI_MODE = 0, CF_AO_MODE = 2, CF_AI_SRC = 4;
  localparam int CF_AO_SRC = 6, CF_AI_REF_EN = 8, CF_AI_REF_SRC = 9;
  localparam int CMD_AI_ARM = 0, CMD_AI_SW = 1, CMD_AI_STOP = 2;
  localparam int CMD_AO_ARM = 4, CMD_AO_SW = 5, CMD_AO_STOP = 6;
  localparam int CMD_ABORT_OFS = 1;
  localparam int IRQ_W = 5;
  localparam int IB_AI_START = 0, IB_AI_DONE = 1, IB_AO_START = 2;
  localparam int IB_AO_DONE = 3, IB_MODE_ERR = 4;
  localparam logic [9:0] CTRL_RST = 10'h000;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [15:0] POST_RST = 16'h0001;
  localparam logic [IRQ_W-1:0] IRQ_RST = 5'h00;
  // ==========================================================
  // timing
  localparam logic [7:0] REF_MHZ = 8'h30;
  localparam logic [7:0] CORE_MHZ = 8'h7d;
  localparam logic [3:0] LINK_HALF = 4'h2;
  localparam logic [2:0] TRIG_HOLD = 3'h4;
  localparam longint STOP_WAIT_S = 20;
  localparam longint CORE_HZ = 125000000;
  localparam longint STOP_WAIT_CYC = STOP_WAIT_S * CORE_HZ;
endpackage

// ==== rtl/mmsl_sync.sv ====
// mmsl_sync: two-flop synchroniser with rising edge detect
// assumes asynchronous inputs, one core clock
`timescale 1ns/100ps
`default_nettype none
module mmsl_sync
  import mmsl_pkg::*;
#(
  parameter int W = 4
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // async inputs and synced outputs
  input wire logic [W-1:0] d,
  output logic [W-1:0] lvl,
  output logic [W-1:0] rise
);
  // ==========================================================
  // stages: first stage read only by second
  logic [W-1:0] s1; // metastable catch
  logic [W-1:0] s2; // synced level
  logic [W-1:0] s3; // delayed for edge
  // shift chain
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
    end
  end
  assign lvl = s2;
  assign rise = s2 & ~s3;
endmodule // mmsl_sync
`default_nettype wire

// ==== rtl/mmsl_sub.sv ====
// mmsl_sub: one subsystem's arm/run/post engine and sample pacer
// assumes go/ref_trig/base_tick are one-cycle core-clock pulses
`timescale 1ns/100ps
`default_nettype none
module mmsl_sub
  import mmsl_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // control and events
  input wire mmsl_ctl_t ctl,
  input wire logic go,
  input wire logic ref_trig,
  input wire logic base_tick,
  input wire logic [31:0] stop_wait,
  // status
  output mmsl_sts_t sts
);
  // ==========================================================
  // state
  mmsl_state_t state, next_state;
  logic [15:0] pace; // pacer count
  logic [15:0] left; // post scans left
  logic [31:0] wait_cnt; // stuck-stop timer
  logic sample, started, done;
  wire logic in_run = (state == S_RUN) || (state == S_POST);
  wire logic hit = base_tick && (pace == ctl.div);
  wire logic slave = (ctl.mode == MMSL_SLAVE);
  wire logic take_ref = (state == S_RUN) && ctl.ref_en && ref_trig;
  // next state
  always_comb begin
    next_state = state;
    case (state)
      S_IDLE: if (ctl.arm) next_state = S_ARMED;
      S_ARMED: begin
        // waits silently until trigger arrives
        if (ctl.stop) next_state = slave ? S_STOPW : S_IDLE;
        else if (go) next_state = S_RUN;
      end
      S_RUN: begin
        // only own stop ends a run
        if (ctl.stop) next_state = S_IDLE;
        else if (take_ref) next_state = S_POST;
      end
      S_POST: begin
        if (ctl.stop) next_state = S_IDLE;
        else if (hit && left == 16'h0001) next_state = S_IDLE;
      end
      S_STOPW: if (wait_cnt >= stop_wait) next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end
  // state, pacer and counters
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= S_IDLE;
      pace <= 16'h0000;
      left <= 16'h0000;
      wait_cnt <= 32'h0000_0000;
      sample <= 1'b0;
      started <= 1'b0;
      done <= 1'b0;
    end else begin
      state <= next_state;
      // pacer held clear until run starts: fixed phase per run
      if (!in_run) pace <= 16'h0000;
      else if (hit) pace <= 16'h0000;
      else if (base_tick) pace <= pace + 16'h0001;
      if (take_ref) left <= ctl.post;
      else if (state == S_POST && hit) left <= left - 16'h0001;
      wait_cnt <= (state == S_STOPW) ? wait_cnt + 32'h1 : 32'h0;
      sample <= in_run && hit;
      started <= (state == S_ARMED) && go && !ctl.stop;
      done <= (state == S_POST) && (next_state == S_IDLE) && !ctl.stop;
    end
  end
  assign sts = '{state: state, sample: sample, started: started, done: done};
  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_go;
    state == S_ARMED && go && !ctl.stop |=> state == S_RUN ##[1:2] 1;
  endproperty
  a_go: assert property (p_go) else $error("armed go not run");
  property p_ref;
    take_ref && !ctl.stop |=> state == S_POST && left == $past(ctl.post);
  endproperty
  a_ref: assert property (p_ref) else $error("ref not taken");
  property p_stuck;
    state == S_ARMED && ctl.stop && slave |=> state == S_STOPW;
  endproperty
  a_stuck: assert property (p_stuck) else $error("no stop wait");
  property p_keep;
    state == S_RUN && !ctl.stop && !take_ref |=> state == S_RUN;
  endproperty
  a_keep: assert property (p_keep) else $error("run dropped");
  property p_wait;
    state == S_ARMED && !go && !ctl.stop |=> state == S_ARMED && !sample;
  endproperty
  a_wait: assert property (p_wait) else $error("armed moved");
endmodule // mmsl_sub
`default_nettype wire

// ==== rtl/mmsl_top.sv ====
// mmsl_top: multi-module sync link, register port, interrupt
// assumes link pins asynchronous, threshold trigger on core clock
`timescale 1ns/100ps
`default_nettype none
module mmsl_top
  import mmsl_pkg::*;
#(
  parameter logic [31:0] STOP_WAIT = 32'(STOP_WAIT_CYC)
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  // local trigger sources
  input wire logic ext_trig,
  input wire logic thr_trig,
  // input link clock pin
  input wire logic ain_clk_in,
  output logic ain_clk_out,
  output logic ain_clk_oe_b,
  // input link trigger pin
  input wire logic ain_trig_in,
  output logic ain_trig_out,
  output logic ain_trig_oe_b,
  // output_sync_connector trigger pin
  input wire logic output_sync_trig_in,
  output logic output_sync_trig_out,
  output logic output_sync_trig_oe_b,
  // converter pacing
  output logic ai_sample,
  output logic ao_sample,
  // interrupt
  output logic irq
);
  // ==========================================================
  // helpers
  // start source select: 0 software, 1 external, 2 threshold
  function automatic logic pick(input logic [1:0] src,
                                input logic sw, input logic ext,
                                input logic thr);
    pick = (src == 2'b00) ? sw : (src == 2'b01) ? ext :
           (src == 2'b10) ? thr : 1'b0;
  endfunction
  // one subsystem master, the other slave
  function automatic logic clash(input logic [9:0] c);
    logic [1:0] a;
    logic [1:0] o;
    a = c[CF_AI_MODE +: 2];
    o = c[CF_AO_MODE +: 2];
    clash = (a == MMSL_MASTER && o == MMSL_SLAVE) ||
            (a == MMSL_SLAVE && o == MMSL_MASTER);
  endfunction
  // ==========================================================
  // registers
  logic [9:0] ctrl; // modes and sources
  logic [IRQ_W-1:0] irq_stat; // sticky events
  logic [IRQ_W-1:0] irq_mask; // enables
  logic [15:0] ai_div, ao_div; // pacer divide minus one
  logic [15:0] ai_post, ao_post; // post scan counts
  // ==========================================================
  // address decode
  wire logic sel_ctrl = addr == OFF_CTRL;
  wire logic sel_cmd = addr == OFF_CMD;
  wire logic sel_stat = addr == OFF_STATUS;
  wire logic sel_istat = addr == OFF_IRQ_STAT;
  wire logic sel_imask = addr == OFF_IRQ_MASK;
  wire logic sel_aid = addr == OFF_AI_DIV;
  wire logic sel_aod = addr == OFF_AO_DIV;
  wire logic sel_aip = addr == OFF_AI_POST;
  wire logic sel_aop = addr == OFF_AO_POST;
  wire logic wr_ctrl = wr_en && sel_ctrl;
  wire logic [7:0] cmd = (wr_en && sel_cmd) ? wr_data[7:0] : 8'h00;
  // conflicting mode write is refused
  wire logic bad_mode = wr_ctrl && clash(wr_data[9:0]);
  // ==========================================================
  // decoded control fields
  wire mmsl_mode_t ai_mode = mmsl_mode_t'(ctrl[CF_AI_MODE +: 2]);
  wire mmsl_mode_t ao_mode = mmsl_mode_t'(ctrl[CF_AO_MODE +: 2]);
  wire logic ai_master = ai_mode == MMSL_MASTER;
  wire logic ai_slave = ai_mode == MMSL_SLAVE;
  wire logic ao_master = ao_mode == MMSL_MASTER;
  wire logic ao_slave = ao_mode == MMSL_SLAVE;
  wire logic ai_ref_en = ctrl[CF_AI_REF_EN];
  wire logic ai_abort = cmd[CMD_AI_STOP + CMD_ABORT_OFS];
  wire logic ao_abort = cmd[CMD_AO_STOP + CMD_ABORT_OFS];
  // ==========================================================
  // pin synchronisers
  logic [3:0] pin_lvl; // synced levels
  logic [3:0] pin_rise; // synced rising edges
  mmsl_sync #(.W(4)) u_sync (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .d({ext_trig, output_sync_trig_in, ain_trig_in, ain_clk_in}),
    .lvl(pin_lvl),
    .rise(pin_rise)
  );
  wire logic link_clk_rise = pin_rise[0];
  wire logic link_trig_rise = pin_rise[1];
  wire logic osync_rise = pin_rise[2];
  wire logic ext_rise = pin_rise[3];
  // threshold trigger is on-domain: edge only
  logic thr_q;
  wire logic thr_rise = thr_trig && !thr_q;
  // ==========================================================
  // local 48 MHz reference by phase accumulator
  logic [7:0] acc; // phase in core cycles
  logic [3:0] hcnt; // ref ticks per half link period
  logic lclk; // local link clock level
  wire logic [7:0] acc_sum = acc + REF_MHZ;
  wire logic ref_tick = acc_sum >= CORE_MHZ;
  wire logic half_end = ref_tick && (hcnt == LINK_HALF - 4'h1);
  wire logic local_base = half_end && !lclk;
  // reference generator
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      acc <= 8'h00;
      hcnt <= 4'h0;
      lclk <= 1'b0;
      thr_q <= 1'b0;
    end else begin
      acc <= ref_tick ? acc_sum - CORE_MHZ : acc_sum;
      if (half_end) hcnt <= 4'h0;
      else if (ref_tick) hcnt <= hcnt + 4'h1;
      if (half_end) lclk <= !lclk;
      thr_q <= thr_trig;
    end
  end
  // ==========================================================
  // timebase per subsystem
  // slaves follow link clock, none and master the local one
  wire logic ai_base = ai_slave ? link_clk_rise : local_base;
  // output slave takes clock from input link, not its own line; none and master the local one
  wire logic ao_base = ao_slave ? link_clk_rise : local_base;
  // ==========================================================
  // triggers
  // slave starts only from the link trigger
  wire logic ai_go = ai_slave ? link_trig_rise :
    pick(ctrl[CF_AI_SRC +: 2], cmd[CMD_AI_SW], ext_rise, thr_rise);
  // slave reference also from link
  wire logic ai_ref = ai_slave ? link_trig_rise :
    (ctrl[CF_AI_REF_SRC] ? thr_rise : ext_rise);
  wire logic ao_go = ao_slave ? osync_rise :
    pick(ctrl[CF_AO_SRC +: 2], cmd[CMD_AO_SW], ext_rise, thr_rise);
  // ==========================================================
  // subsystem engines
  mmsl_sts_t ai_sts, ao_sts;
  wire mmsl_ctl_t ai_ctl = '{mode: ai_mode, arm: cmd[CMD_AI_ARM],
    stop: cmd[CMD_AI_STOP] | ai_abort, ref_en: ai_ref_en,
    div: ai_div, post: ai_post};
  wire mmsl_ctl_t ao_ctl = '{mode: ao_mode, arm: cmd[CMD_AO_ARM],
    stop: cmd[CMD_AO_STOP] | ao_abort, ref_en: 1'b0,
    div: ao_div, post: ao_post};
  mmsl_sub u_ai (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ctl(ai_ctl),
    .go(ai_go),
    .ref_trig(ai_ref),
    .base_tick(ai_base),
    .stop_wait(STOP_WAIT),
    .sts(ai_sts)
  );
  mmsl_sub u_ao (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .ctl(ao_ctl),
    .go(ao_go),
    .ref_trig(1'b0),
    .base_tick(ao_base),
    .stop_wait(STOP_WAIT),
    .sts(ao_sts)
  );
  assign ai_sample = ai_sts.sample;
  assign ao_sample = ao_sts.sample;
  // ==========================================================
  // masters relay start onto their link; input master also relays reference
  logic ai_ref_seen; // reference accepted last cycle
  wire logic ai_take = ai_sts.state == S_RUN && ai_ref_en && ai_ref;
  logic [2:0] ai_hold, ao_hold; // pulse stretch counters
  wire logic ai_pulse = ai_master && (ai_sts.started || ai_ref_seen);
  wire logic ao_pulse = ao_master && ao_sts.started;
  // link drivers: only a master ever drives
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ai_ref_seen <= 1'b0;
      ai_hold <= 3'h0;
      ao_hold <= 3'h0;
      ain_clk_out <= 1'b0;
      ain_clk_oe_b <= 1'b1;
      ain_trig_out <= 1'b0;
      ain_trig_oe_b <= 1'b1;
      output_sync_trig_out <= 1'b0;
      output_sync_trig_oe_b <= 1'b1;
    end else begin
      ai_ref_seen <= ai_take && !ai_ctl.stop;
      ai_hold <= ai_pulse ? TRIG_HOLD : ai_hold - 3'(ai_hold != 3'h0);
      ao_hold <= ao_pulse ? TRIG_HOLD : ao_hold - 3'(ao_hold != 3'h0);
      // clock runs free in master mode so slaves keep pacing
      ain_clk_out <= lclk;
      ain_clk_oe_b <= !(ai_master || ao_master);
      ain_trig_out <= ai_hold != 3'h0;
      ain_trig_oe_b <= !ai_master;
      output_sync_trig_out <= ao_hold != 3'h0;
      output_sync_trig_oe_b <= !ao_master;
    end
  end
  // ==========================================================
  // interrupt events
  wire logic [IRQ_W-1:0] ev = {bad_mode, ao_sts.done, ao_sts.started,
                               ai_sts.done, ai_sts.started};
  wire logic [IRQ_W-1:0] w1c = (wr_en && sel_istat) ?
                               wr_data[IRQ_W-1:0] : '0;
  // ==========================================================
  // register writes
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl <= CTRL_RST;
      irq_stat <= IRQ_RST;
      irq_mask <= IRQ_RST;
      ai_div <= DIV_RST;
      ao_div <= DIV_RST;
      ai_post <= POST_RST;
      ao_post <= POST_RST;
      irq <= 1'b0;
    end else begin
      // mode changes only on accepted write
      if (wr_ctrl && !bad_mode) ctrl <= wr_data[9:0];
      // set beats clear
      irq_stat <= (irq_stat & ~w1c) | ev;
      if (wr_en && sel_imask) irq_mask <= wr_data[IRQ_W-1:0];
      if (wr_en && sel_aid) ai_div <= wr_data[15:0];
      if (wr_en && sel_aod) ao_div <= wr_data[15:0];
      if (wr_en && sel_aip) ai_post <= wr_data[15:0];
      if (wr_en && sel_aop) ao_post <= wr_data[15:0];
      irq <= |(irq_stat & irq_mask);
    end
  end
  // ==========================================================
  // read mux
  wire logic [31:0] status_w = {24'h000000, pin_lvl[1], pin_lvl[0],
                                ao_sts.state, ai_sts.state};
  wire logic [31:0] rd_mux =
      ({32{sel_ctrl}} & {22'h000000, ctrl}) |
      ({32{sel_stat}} & status_w) |
      ({32{sel_istat}} & {27'h0000000, irq_stat}) |
      ({32{sel_imask}} & {27'h0000000, irq_mask}) |
      ({32{sel_aid}} & {16'h0000, ai_div}) |
      ({32{sel_aod}} & {16'h0000, ao_div}) |
      ({32{sel_aip}} & {16'h0000, ai_post}) |
      ({32{sel_aop}} & {16'h0000, ao_post});
  // read data one cycle after strobe, zero otherwise
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) rd_data <= 32'h0000_0000;
    else rd_data <= rd_en ? rd_mux : 32'h0000_0000;
  end
  // ==========================================================
  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  property p_drive;
    ai_master |=> !ain_clk_oe_b && !ain_trig_oe_b;
  endproperty
  a_drive: assert property (p_drive) else $error("master not driving");
  property p_slave_local;
    ai_slave && ai_sts.state == S_ARMED && !link_trig_rise && !ai_ctl.stop
      |=> ai_sts.state == S_ARMED;
  endproperty
  a_slave_local: assert property (p_slave_local) else $error("slave local start");
  property p_none;
    !ai_master && !ao_master |=> ain_clk_oe_b && ain_trig_oe_b;
  endproperty
  a_none: assert property (p_none) else $error("link driven off master");
  property p_hold;
    !wr_ctrl |=> $stable(ctrl);
  endproperty
  a_hold: assert property (p_hold) else $error("mode changed alone");
  property p_one;
    ai_slave |=> ain_trig_oe_b ##1 ain_trig_oe_b || !ai_slave;
  endproperty
  a_one: assert property (p_one) else $error("slave drives trigger");
  property p_clash;
    bad_mode |=> $stable(ctrl) && irq_stat[IB_MODE_ERR];
  endproperty
  a_clash: assert property (p_clash) else $error("clash accepted");
  property p_ao_clk;
    ao_slave |-> ao_base == link_clk_rise;
  endproperty
  a_ao_clk: assert property (p_ao_clk) else $error("ao not on link clock");
  property p_relay;
    ai_master && ai_sts.started |=> ##1 ain_trig_out [*4];
  endproperty
  a_relay: assert property (p_relay) else $error("trigger not relayed");
  property p_irq;
    |(irq_stat & irq_mask) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing");
  // output-side drivers, shared clock, link reference and register port
  property p_ao_drive;
    ao_master |=> !output_sync_trig_oe_b;
  endproperty
  a_ao_drive: assert property (p_ao_drive) else $error("ao master not driving");
  property p_ao_none;
    !ao_master |=> output_sync_trig_oe_b;
  endproperty
  a_ao_none: assert property (p_ao_none) else $error("ao line driven off master");
  property p_clk_out;
    ai_master || ao_master |=> !ain_clk_oe_b && ain_clk_out == $past(lclk);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("link clock not local");
  property p_ref_link;
    ai_slave && ai_sts.state == S_RUN && ai_ref_en && link_trig_rise && !ai_ctl.stop
      |=> ai_sts.state == S_POST;
  endproperty
  a_ref_link: assert property (p_ref_link) else $error("link reference lost");
  property p_set;
    (|ev) |=> (irq_stat & $past(ev)) == $past(ev);
  endproperty
  a_set: assert property (p_set) else $error("event lost against clear");
  property p_rd_idle;
    !rd_en |=> rd_data == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
endmodule // mmsl_top
`default_nettype wire

// ==== verification/mmsl_peer.sv ====
// mmsl_peer: behavioural peer master on the input sync link
// assumes the bench resolves each line with the block's drivers
`timescale 1ns/100ps
`default_nettype none
module mmsl_peer (
  // bench controls
  input wire logic clk_run,
  input wire logic trig_req,
  // link lines, pulled low while idle
  output logic lnk_clk,
  output logic lnk_trig
);
  // ====================
  // 64 ns clock while run is set, still otherwise
  initial lnk_clk = 1'b0;
  always #32 lnk_clk = clk_run ? ~lnk_clk : 1'b0;
  // one 128 ns trigger per request edge
  initial lnk_trig = 1'b0;
  always @(posedge trig_req) begin
    lnk_trig = 1'b1;
    #128 lnk_trig = 1'b0;
  end
endmodule // mmsl_peer
`default_nettype wire

// ==== verification/test_multi_module_sync_link.sv ====
// test_multi_module_sync_link: register-driven bench with a peer master
// assumes package and design compiled first; stop wait cut to 50
`timescale 1ns/100ps
`default_nettype none
module test_multi_module_sync_link
  import mmsl_pkg::*;
;
  // ====================
  // stimulus, outputs, resolved link lines
  logic core_clk = 1'b0, rst_b = 1'b0, wr_en = 1'b0, rd_en = 1'b0;
  logic ext_trig = 1'b0, thr_trig = 1'b0, run = 1'b0, treq = 1'b0, pend = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wr_data = 32'h00000000;
  logic [31:0] rd_data;
  logic [63:0] ee;
  logic ai_sample, ao_sample, irq, c_o, c_b, t_o, t_b, s_o, s_b;
  wire logic pclk, ptrig, lclk, ltrig, strig;
  logic [63:0] exp_q[$];
  logic [31:0] cmds [2] = '{32'h4, 32'h8};
  int bad_count = 0, samples_checked = 0, ns = 0, nc = 0, nt = 0, na = 0, no = 0;
  int d, n0, p;
  // block drives when enabled, else peer or pull-down
  assign lclk = c_b ? pclk : c_o;
  assign ltrig = t_b ? ptrig : t_o;
  assign strig = s_b ? 1'b0 : s_o;
  always #4 core_clk = ~core_clk;
  mmsl_top #(.STOP_WAIT(32'd50)) DUT (.core_clk(core_clk), .rst_b(rst_b), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .ext_trig(ext_trig), .thr_trig(thr_trig), .ain_clk_in(lclk), .ain_clk_out(c_o),
    .ain_clk_oe_b(c_b), .ain_trig_in(ltrig), .ain_trig_out(t_o), .ain_trig_oe_b(t_b),
    .output_sync_trig_in(strig), .output_sync_trig_out(s_o),
    .output_sync_trig_oe_b(s_b), .ai_sample(ai_sample), .ao_sample(ao_sample), .irq(irq));
  mmsl_peer peer (.clk_run(run), .trig_req(treq), .lnk_clk(pclk), .lnk_trig(ptrig));
  // ====================
  // counters for pacing and link activity
  always @(posedge core_clk) if (ai_sample === 1'b1) ns <= ns + 1;
  always @(posedge core_clk) if (ao_sample === 1'b1) na <= na + 1;
  always @(posedge lclk) if (c_b === 1'b0) nc <= nc + 1;
  always @(posedge t_o) nt <= nt + 1;
  always @(posedge s_o) no <= no + 1;
  // watcher: oldest note against each read answer
  always @(posedge core_clk) begin
    if (pend) begin
      ee = exp_q.pop_front();
      chk((rd_data & ee[63:32]) === ee[31:0], "read data");
    end
    pend <= rd_en;
  end
  // ====================
  // helpers
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  // one-cycle write strobe, then a quiet cycle
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    addr <= a;
    wr_data <= v;
    wr_en <= 1'b1;
    cyc(1);
    wr_en <= 1'b0;
    cyc(1);
  endtask
  // read strobe; answer noted for the watcher
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    addr <= a;
    rd_en <= 1'b1;
    exp_q.push_back({m, e & m});
    cyc(1);
    rd_en <= 1'b0;
    cyc(1);
  endtask
  // peer trigger pulse, then sync settle time
  task automatic trig();
    treq <= 1'b1;
    cyc(1);
    treq <= 1'b0;
    cyc(15);
  endtask
  task automatic end_sim();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ====================
  // main sequence
  initial begin
    void'($urandom(73744));
    fork
      begin
        cyc(30000);
        bad_count++;
        end_sim();
      end
    join_none
    cyc(20);
    rst_b <= 1'b1;
    cyc(2);
    // reset values, default none mode
    chk(c_b === 1'b1 && t_b === 1'b1 && s_b === 1'b1 && irq === 1'b0, "idle");
    rd(OFF_CTRL, 32'(CTRL_RST));
    rd(OFF_AI_POST, 32'(POST_RST));
    rd(8'h40, 32'h0);
    rd(OFF_CMD, 32'h0);
    // none mode paces from the local base
    d = $urandom_range(3, 0);
    wr(OFF_AI_DIV, 32'(d));
    wr(OFF_CMD, 32'h1);
    wr(OFF_CMD, 32'h2);
    n0 = ns;
    cyc(200);
    chk(ns > n0 && c_b === 1'b1 && t_b === 1'b1, "none pacing");
    wr(OFF_CMD, 32'h4);
    $display("test none done");
    // master drives trigger and clock
    wr(OFF_CTRL, 32'(MMSL_MASTER));
    wr(OFF_IRQ_STAT, 32'h1f);
    wr(OFF_CMD, 32'h1);
    wr(OFF_CMD, 32'h2);
    cyc(40);
    chk(c_b === 1'b0 && t_b === 1'b0 && nt == 1 && nc > 0, "master link");
    rd(OFF_STATUS, 32'(S_RUN), 32'h7);
    rd(OFF_IRQ_STAT, 32'h1, 32'h1);
    wr(OFF_CMD, 32'h4);
    wr(OFF_CTRL, 32'h0);
    $display("test master done");
    // output side as master: own trigger line, shared clock, pacing
    wr(OFF_CTRL, 32'h4);
    wr(OFF_CMD, 32'h10);
    n0 = na;
    wr(OFF_CMD, 32'h20);
    cyc(60);
    chk(na > n0 && s_b === 1'b0 && c_b === 1'b0 && no == 1, "ao master");
    rd(OFF_STATUS, 32'(S_RUN) << 3, 32'h38);
    wr(OFF_CMD, 32'h40);
    wr(OFF_CTRL, 32'h0);
    $display("test output done");
    // mixed master and slave refused; interrupt raise, mask, clear
    wr(OFF_IRQ_STAT, 32'h1f);
    wr(OFF_CTRL, 32'h9);
    wr(OFF_CTRL, 32'h6);
    rd(OFF_CTRL, 32'h0);
    rd(OFF_IRQ_STAT, 32'h10, 32'h10);
    chk(irq === 1'b0, "irq masked");
    wr(OFF_IRQ_MASK, 32'h10);
    cyc(2);
    chk(irq === 1'b1, "irq up");
    wr(OFF_IRQ_STAT, 32'h10);
    cyc(2);
    chk(irq === 1'b0, "irq clear");
    wr(OFF_IRQ_MASK, 32'h0);
    $display("test refuse done");
    // slave ignores local start, waits, then follows the link
    d = $urandom_range(3, 0);
    wr(OFF_AI_DIV, 32'(d));
    wr(OFF_CTRL, 32'(MMSL_SLAVE) | (32'($urandom_range(2, 0)) << 4));
    n0 = ns;
    wr(OFF_CMD, 32'h1);
    wr(OFF_CMD, 32'h2);
    repeat (30) begin
      ext_trig <= 1'($urandom);
      thr_trig <= 1'($urandom);
      cyc(1);
    end
    ext_trig <= 1'b0;
    thr_trig <= 1'b0;
    run <= 1'b1;
    cyc(20);
    rd(OFF_STATUS, 32'(S_ARMED), 32'h7);
    chk(ns == n0 && c_b === 1'b1 && t_b === 1'b1, "slave waits");
    trig();
    rd(OFF_STATUS, 32'(S_RUN), 32'h7);
    p = 50 / (d + 1);
    n0 = ns;
    cyc(400);
    chk(ns >= n0 + p - 1 && ns <= n0 + p + 1, "slave rate");
    rd(OFF_STATUS, 32'(S_RUN), 32'h7);
    wr(OFF_CMD, 32'h4);
    rd(OFF_STATUS, 32'(S_IDLE), 32'h7);
    $display("test slave done");
    // reference trigger from the link, post count
    run <= 1'b0;
    p = $urandom_range(4, 1);
    wr(OFF_AI_DIV, 32'h0);
    wr(OFF_AI_POST, 32'(p));
    wr(OFF_CTRL, 32'h102);
    wr(OFF_CMD, 32'h1);
    trig();
    rd(OFF_STATUS, 32'(S_RUN), 32'h7);
    n0 = ns;
    trig();
    rd(OFF_STATUS, 32'(S_POST), 32'h7);
    run <= 1'b1;
    cyc(100);
    chk(ns == n0 + p, "post count");
    rd(OFF_IRQ_STAT, 32'h2, 32'h2);
    run <= 1'b0;
    wr(OFF_CMD, 32'h4);
    $display("test reference done");
    // late slave never starts; stop and abort wait it out
    foreach (cmds[i]) begin
      wr(OFF_CTRL, 32'(MMSL_SLAVE));
      trig();
      wr(OFF_CMD, 32'h1);
      cyc(20);
      rd(OFF_STATUS, 32'(S_ARMED), 32'h7);
      wr(OFF_CMD, cmds[i]);
      rd(OFF_STATUS, 32'(S_STOPW), 32'h7);
      cyc(30);
      rd(OFF_STATUS, 32'(S_STOPW), 32'h7);
      cyc(30);
      rd(OFF_STATUS, 32'(S_IDLE), 32'h7);
    end
    rd(OFF_CTRL, 32'(MMSL_SLAVE));
    $display("test late slave done");
    cyc(2);
    end_sim();
  end
endmodule // test_multi_module_sync_link
`default_nettype wire
